// file: core/dar_consts.svh
// Purpose: Timing and field constants of the dual converter serial readout
// Assumes: Counts are in serial clock falling edges after frame select falls
// Notes:   Shared by both ends and the buffer
// Overview of operation
// - Host clock is conversion and shift clock
// - Frame fall samples, converts, drives both lines
// - Host gives at least 14 clocks
// - Back to track after 13th falling edge
// - Sixteen clock word adds two trailing zeros
// - Frame rise aborts, lines float at once
// - Held longer, line A chains converter B
// - Held longer, line B chains converter A
// - Chained line floats at 32nd falling edge
// - Frame fall gives zero, first edge another
// - Twelve bits MSB first, last at 13th
// - Rising sampler sees LSB at 13th rise
// - Rising edges before first falling ignored
// - Coincident falling edge with frame fall uncounted
// - Host frames each word, 16 or 14; the host here frames any i_host_word_length (the bench also uses 8 and 32)
// - Eight clock burst then rise powers down
// - Host starts conversions at equal spacing
// - Host may sample on falling edge
// - Rise between edges 2 and 10 powers down
// - Rise before edge 2 keeps power state
`ifndef DAR_CONSTS_SVH
`define DAR_CONSTS_SVH
`define DAR_RES_W        12
`define DAR_LEAD_ZEROS   2
`define DAR_TRACK_EDGE   13
`define DAR_WORD_MIN     14
`define DAR_WORD_LONG    16
`define DAR_CHAIN_END    32
`define DAR_PD_LO        2
`define DAR_PD_HI        10
`define DAR_PD_BURST     8
`define DAR_CNT_W        6
`define DAR_DIV_DEF      8
`define DAR_GAP_DEF      4
`define DAR_FIFO_DEPTH   16
`endif

// file: core/dar_dev.sv
`timescale 1ns/100ps
`include "dar_consts.svh"
// Purpose: Converter end: samples, converts and shifts out two results
// Assumes: Serial clock and frame select are pins, synchronised here
// Notes:   Conversion results arrive as parallel inputs, held at frame fall
module dar_dev (
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  dar_if.dev                         lnk,
  input  wire logic [`DAR_RES_W-1:0] i_conv_a,
  input  wire logic [`DAR_RES_W-1:0] i_conv_b,
  output logic                       o_hold,
  output logic                       o_converting,
  output dar_pkg::dar_pwr_t          o_power
);
  import dar_pkg::*;
  // ==========================================================
  // Pin synchronisers
  logic [1:0] fs_s_q;
  logic [1:0] ck_s_q;
  logic       fs_q;
  logic       ck_q;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      fs_s_q <= 2'b11;
      ck_s_q <= 2'b11;
      fs_q   <= 1'b1;
      ck_q   <= 1'b1;
    end else begin
      fs_s_q <= {fs_s_q[0], lnk.frame_n};
      ck_s_q <= {ck_s_q[0], lnk.sclk};
      fs_q   <= fs_s_q[1];
      ck_q   <= ck_s_q[1];
    end
  end
  wire fs_fall = fs_q && !fs_s_q[1];
  wire fs_rise = !fs_q && fs_s_q[1];
  wire ck_fall = ck_q && !ck_s_q[1];
  wire ck_rise = !ck_q && ck_s_q[1];
  // ==========================================================
  // Frame state
  logic                  act_q;
  logic [`DAR_CNT_W-1:0] cnt_q;
  logic [31:0]           sa_q;
  logic [31:0]           sb_q;
  logic                  oe_q;
  logic                  hold_q;
  logic                  trk_pend_q;
  dar_pwr_t              pwr_q;
  wire                   cnt_edge = act_q && ck_fall && !fs_fall;
  wire [`DAR_CNT_W-1:0]  cnt_nx   = cnt_q + `DAR_CNT_W'(1);
  wire                   pd_win   = (cnt_q >= `DAR_CNT_W'(`DAR_PD_LO)) &&
                                    (cnt_q <  `DAR_CNT_W'(`DAR_PD_HI));
  wire                   wake_ok  = (cnt_q >= `DAR_CNT_W'(`DAR_PD_HI));
  wire                   early    = (cnt_q <  `DAR_CNT_W'(`DAR_PD_LO));
  // Words: two zeros, 12 bits, two zeros, then other converter, four zeros
  wire [31:0]            word_a   = {2'b00, i_conv_a, 2'b00, i_conv_b, 4'h0};
  wire [31:0]            word_b   = {2'b00, i_conv_b, 2'b00, i_conv_a, 4'h0};
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      act_q      <= 1'b0;
      cnt_q      <= '0;
      sa_q       <= '0;
      sb_q       <= '0;
      oe_q       <= 1'b0;
      hold_q     <= 1'b0;
      trk_pend_q <= 1'b0;
      pwr_q      <= DAR_PWR_NORMAL;
    end else if (fs_fall) begin
      act_q      <= 1'b1;
      cnt_q      <= '0;
      sa_q       <= word_a;
      sb_q       <= word_b;
      oe_q       <= 1'b1;
      hold_q     <= 1'b1;
      trk_pend_q <= 1'b0;
    end else if (fs_rise) begin
      act_q      <= 1'b0;
      oe_q       <= 1'b0;
      hold_q     <= 1'b0;
      trk_pend_q <= 1'b0;
      if (act_q && pd_win) begin
        pwr_q <= (pwr_q == DAR_PWR_NORMAL) ? DAR_PWR_PARTIAL : DAR_PWR_FULL;
      end else if (act_q && wake_ok) begin
        pwr_q <= DAR_PWR_NORMAL;
      end else if (act_q && early && pwr_q == DAR_PWR_NORMAL) begin
        pwr_q <= DAR_PWR_NORMAL;
      end
    end else if (cnt_edge) begin
      cnt_q <= cnt_nx;
      sa_q  <= {sa_q[30:0], 1'b0};
      sb_q  <= {sb_q[30:0], 1'b0};
      if (cnt_nx == `DAR_CNT_W'(`DAR_TRACK_EDGE)) begin
        trk_pend_q <= 1'b1;
      end
      if (cnt_nx == `DAR_CNT_W'(`DAR_CHAIN_END)) begin
        oe_q  <= 1'b0;
        act_q <= 1'b0;
      end
    end else if (trk_pend_q && ck_rise) begin
      hold_q     <= 1'b0;
      trk_pend_q <= 1'b0;
    end
  end
  // ==========================================================
  // Outputs
  wire line_en = oe_q && !fs_s_q[1];
  assign lnk.line_a_o  = sa_q[31];
  assign lnk.line_b_o  = sb_q[31];
  assign lnk.line_a_oe = line_en;
  assign lnk.line_b_oe = line_en;
  assign o_hold        = hold_q;
  assign o_converting  = hold_q;
  assign o_power       = pwr_q;
endmodule

// file: core/dar_fifo.sv
`timescale 1ns/100ps
`include "dar_consts.svh"
// Purpose: Word buffer with valid and ready on both sides
// Assumes: Single clock, synchronous reset
// Notes:   Depth a power of two
module dar_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = `DAR_FIFO_DEPTH
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  wire          full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire          empty = (wp_q == rp_q);
  wire          push  = i_valid && !full;
  wire          pop   = o_valid && i_ready;
  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data  = mem[rp_q[AW-1:0]];
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= i_data;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_q + (AW+1)'(push);
      rp_q <= rp_q + (AW+1)'(pop);
    end
  end
endmodule

// file: core/dar_host.sv
`timescale 1ns/100ps
`include "dar_consts.svh"
// Purpose: Host port: frames a word, makes serial clock, captures results
// Assumes: Serial clock made by divider of own clock
// Notes:   Captures both lines on falling edge; words pass through a FIFO
module dar_host #(
  parameter int DIV = `DAR_DIV_DEF,
  parameter int GAP = `DAR_GAP_DEF
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_srst,
  dar_if.host                           lnk,
  input  wire logic                     i_start,
  input  wire logic [`DAR_CNT_W-1:0]    i_host_word_length,
  output logic                          o_busy,
  output logic                          o_valid,
  input  wire logic                     i_ready,
  output logic [31:0]                   o_data
);
  import dar_pkg::*;
  // ==========================================================
  // Synchronise result lines
  logic [1:0] a_s_q;
  logic [1:0] b_s_q;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      a_s_q <= 2'b11;
      b_s_q <= 2'b11;
    end else begin
      a_s_q <= {a_s_q[0], lnk.result_line_a};
      b_s_q <= {b_s_q[0], lnk.result_line_b};
    end
  end
  // ==========================================================
  // Frame and clock generator
  dar_hst_t              st_q;
  logic [7:0]            div_q;
  logic                  sck_q;
  logic [`DAR_CNT_W-1:0] n_q;
  logic [`DAR_CNT_W-1:0] len_q;
  logic [15:0]           sha_q;
  logic [15:0]           shb_q;
  logic                  push_q;
  logic                  tail_q;
  wire                   f_rdy;
  wire                   half  = (div_q == 8'((DIV / 2) - 1));
  wire                   fall  = (st_q == DAR_H_FRAME) && half && sck_q && !tail_q;
  wire                   done  = fall && (n_q + `DAR_CNT_W'(1) == len_q);
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q   <= DAR_H_IDLE;
      div_q  <= '0;
      sck_q  <= 1'b1;
      n_q    <= '0;
      len_q  <= `DAR_CNT_W'(`DAR_WORD_LONG);
      sha_q  <= '0;
      shb_q  <= '0;
      push_q <= 1'b0;
      tail_q <= 1'b0;
    end else begin
      push_q <= 1'b0;
      case (st_q)
        DAR_H_IDLE: begin
          if (i_start && f_rdy) begin
            st_q  <= DAR_H_FRAME;
            len_q <= i_host_word_length;
            n_q   <= '0;
            div_q  <= '0;
            sck_q  <= 1'b1;
            tail_q <= 1'b0;
          end
        end
        DAR_H_FRAME: begin
          div_q <= half ? '0 : div_q + 8'(1);
          if (half) begin
            sck_q <= tail_q ? 1'b1 : !sck_q;
          end
          if (fall) begin
            n_q   <= n_q + `DAR_CNT_W'(1);
            sha_q <= {sha_q[14:0], a_s_q[1]};
            shb_q <= {shb_q[14:0], b_s_q[1]};
          end
          if (done) begin
            tail_q <= 1'b1;
          end
          // Frame held half a period past last fall
          if (tail_q && half) begin
            st_q   <= DAR_H_GAP;
            tail_q <= 1'b0;
            push_q <= (len_q >= `DAR_CNT_W'(`DAR_WORD_MIN));
            div_q  <= '0;
          end
        end
        DAR_H_GAP: begin
          div_q <= div_q + 8'(1);
          if (div_q == 8'(GAP)) begin
            st_q <= DAR_H_IDLE;
          end
        end
        default: begin
          st_q <= DAR_H_IDLE;
        end
      endcase
    end
  end
  assign lnk.frame_n = (st_q != DAR_H_FRAME);
  assign lnk.sclk    = sck_q;
  assign o_busy      = (st_q != DAR_H_IDLE);
  // ==========================================================
  // Result buffer
  dar_fifo #(.W(32), .DEPTH(`DAR_FIFO_DEPTH)) dar_fifo_i (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_valid (push_q),
    .o_ready (f_rdy),
    .i_data  ({sha_q, shb_q}),
    .o_valid (o_valid),
    .i_ready (i_ready),
    .o_data  (o_data)
  );
endmodule

// file: core/dar_if.sv
`timescale 1ns/100ps
// Purpose: Link between host port and converter readout
// Assumes: Result lines are three-state; enables resolve the wire
// Notes:   No clocking block
interface dar_if;
  logic frame_n;
  logic sclk;
  logic line_a_o;
  logic line_a_oe;
  logic line_b_o;
  logic line_b_oe;
  wire  result_line_a = line_a_oe ? line_a_o : 1'b1;
  wire  result_line_b = line_b_oe ? line_b_o : 1'b1;
  modport host (output frame_n, output sclk, input result_line_a, input result_line_b);
  modport dev  (input frame_n, input sclk, output line_a_o, output line_a_oe,
                output line_b_o, output line_b_oe);
endinterface

// file: core/dar_pkg.sv
// Purpose: Types of the dual converter serial readout
// Assumes: Constants come from dar_consts.svh
// Notes:   Power states and host states
package dar_pkg;
  typedef enum logic [1:0] {
    DAR_PWR_NORMAL  = 2'b00,
    DAR_PWR_PARTIAL = 2'b01,
    DAR_PWR_FULL    = 2'b11
  } dar_pwr_t;
  typedef enum logic [1:0] {
    DAR_H_IDLE  = 2'b00,
    DAR_H_FRAME = 2'b01,
    DAR_H_GAP   = 2'b11
  } dar_hst_t;
endpackage

// file: test/dar_monitor.sv
`timescale 1ns/100ps
// Purpose: Assertions on the link between host port and converter end
// Assumes: Serial clock period of 16 system clocks
// Notes:   Counts serial falls while frame select is low
module dar_monitor (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic frame_n,
  input wire logic sclk,
  input wire logic line_a_o,
  input wire logic line_a_oe,
  input wire logic line_b_o,
  input wire logic line_b_oe
);
  // ==========================================================
  // Serial edge counter
  logic       sclk_q;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  wire        fall = sclk_q & ~sclk;
  wire        rise = ~sclk_q & sclk;
  assign cnt_d = frame_n ? 6'h00 : (fall ? cnt_q + 6'h01 : cnt_q);
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sclk_q <= 1'b1;
      cnt_q  <= 6'h00;
    end else begin
      sclk_q <= sclk;
      cnt_q  <= cnt_d;
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_float_frame_high: assert property (frame_n [*8] |-> !line_a_oe && !line_b_oe)
    else $error("line driven while frame high");
  a_drive_on_fall: assert property ($fell(frame_n) |-> ##[1:8] line_a_oe && line_b_oe)
    else $error("lines not driven after frame fall");
  a_lead_zero: assert property ($rose(line_a_oe) |-> !line_a_o)
    else $error("first bit not zero");
  a_word_zeros: assert property (rise && !frame_n && (cnt_q < 6'h02 || cnt_q == 6'h0e ||
    cnt_q == 6'h0f) |-> !line_a_o && !line_b_o) else $error("zero bit missing");
  a_chain_tail: assert property (rise && !frame_n && (cnt_q == 6'h1c || cnt_q == 6'h1d ||
    cnt_q == 6'h1e || cnt_q == 6'h1f) |-> !line_a_o && !line_b_o) else $error("chain zero missing");
  a_chain_float: assert property (fall && !frame_n && cnt_q == 6'h1f |->
    ##[1:8] !line_a_oe && !line_b_oe) else $error("line driven after 32 falls");
  a_abort_float: assert property ($rose(frame_n) |-> ##[1:8] !line_a_oe && !line_b_oe)
    else $error("line driven after frame rise");
  a_word_length: assert property ($rose(frame_n) |-> cnt_q inside {8, 14, 16, 32})
    else $error("frame length not 8, 14, 16 or 32");
endmodule

// file: test/test_dual_adc_serial_readout.sv
`timescale 1ns/100ps
// Purpose: Self-checking bench, host end facing converter end
// Assumes: Host divider 16 gives a 64 ns serial clock
// Notes:   Both lines also sampled here on serial falls
module test_dual_adc_serial_readout;
  import dar_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic        start = 1'b0;
  logic        rdy = 1'b0;
  logic [5:0]  wlen = 6'h10;
  logic [11:0] ca = 12'h000;
  logic [11:0] cb = 12'h000;
  logic        busy;
  logic        vld;
  logic [31:0] dat;
  logic [31:0] sh_a;
  logic [31:0] sh_b;
  dar_pwr_t    pwr;
  logic        hold;
  logic        conv;
  logic [31:0] hl;
  logic [31:0] cl;
  logic [31:0] rs_a;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cyc = 0;
  always #2 i_clk = ~i_clk;
  // ==========================================================
  // Both ends across the link
  dar_if dar_if_i ();
  dar_host #(.DIV(16), .GAP(4)) dar_host_i (.i_clk(i_clk), .i_srst(i_srst), .lnk(dar_if_i),
    .i_start(start), .i_host_word_length(wlen), .o_busy(busy), .o_valid(vld), .i_ready(rdy),
    .o_data(dat));
  dar_dev dar_dev_i (.i_clk(i_clk), .i_srst(i_srst), .lnk(dar_if_i), .i_conv_a(ca),
    .i_conv_b(cb), .o_hold(hold), .o_converting(conv), .o_power(pwr));
  dar_monitor dar_monitor_i (.i_clk(i_clk), .i_srst(i_srst), .frame_n(dar_if_i.frame_n),
    .sclk(dar_if_i.sclk), .line_a_o(dar_if_i.line_a_o), .line_a_oe(dar_if_i.line_a_oe),
    .line_b_o(dar_if_i.line_b_o), .line_b_oe(dar_if_i.line_b_oe));
  always @(negedge dar_if_i.sclk) begin
    if (!dar_if_i.frame_n) begin
      sh_a <= {sh_a[30:0], dar_if_i.result_line_a};
      sh_b <= {sh_b[30:0], dar_if_i.result_line_b};
      hl   <= {hl[30:0], hold};
      cl   <= {cl[30:0], conv};
    end
  end
  // Rising-edge view of line A
  always @(posedge dar_if_i.sclk) begin
    rs_a <= {rs_a[30:0], dar_if_i.result_line_a};
  end
  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic frame(input logic [5:0] len, input logic [11:0] a, input logic [11:0] b);
    int n;
    @(negedge i_clk);
    ca = a;
    cb = b;
    wlen = len;
    start = 1'b1;
    for (n = 0; n < 40 && busy !== 1'b1; n++) @(negedge i_clk);
    start = 1'b0;
    for (n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge i_clk);
    chk("frame end", {31'h0, busy}, 32'h0);
  endtask
  task automatic pop(input logic [31:0] exp, input bit cmp);
    int n;
    @(negedge i_clk);
    for (n = 0; n < 400 && vld !== 1'b1; n++) @(negedge i_clk);
    chk("valid", {31'h0, vld}, 32'h1);
    if (cmp) chk("word", dat, exp);
    rdy = 1'b1;
    @(negedge i_clk);
    rdy = 1'b0;
  endtask
  function automatic logic [15:0] w(input logic [11:0] r);
    return {2'b00, r, 2'b00};
  endfunction
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // Tests
  initial begin
    int i;
    repeat (20) @(negedge i_clk);
    i_srst = 1'b0;
    frame(6'h10, 12'ha5c, 12'h3c1);
    chk("line a", {16'h0, sh_a[15:0]}, {16'h0, w(12'ha5c)});
    chk("line b", {16'h0, sh_b[15:0]}, {16'h0, w(12'h3c1)});
    chk("hold", {16'h0, hl[15:0]}, 32'h0000fff8);
    chk("converting", {16'h0, cl[15:0]}, 32'h0000fff8);
    chk("rise a", {17'h0, rs_a[15:1]}, {17'h0, 1'b0, 12'ha5c, 2'b00});
    pop({w(12'ha5c), w(12'h3c1)}, 1'b1);
    $display("test word of 16 done");
    frame(6'h0e, 12'hfff, 12'h001);
    chk("short a", {18'h0, sh_a[13:0]}, {20'h0, 12'hfff});
    chk("short b", {18'h0, sh_b[13:0]}, {20'h0, 12'h001});
    pop(32'h0, 1'b0);
    $display("test word of 14 done");
    frame(6'h20, 12'h800, 12'h7ff);
    chk("chain a", sh_a, {2'b00, 12'h800, 2'b00, 12'h7ff, 4'h0});
    chk("chain b", sh_b, {2'b00, 12'h7ff, 2'b00, 12'h800, 4'h0});
    pop({12'h7ff, 4'h0, 12'h800, 4'h0}, 1'b1);
    $display("test chained read done");
    frame(6'h08, 12'h123, 12'h456);
    chk("partial", {30'h0, pwr}, {30'h0, DAR_PWR_PARTIAL});
    frame(6'h08, 12'h123, 12'h456);
    chk("full", {30'h0, pwr}, {30'h0, DAR_PWR_FULL});
    frame(6'h10, 12'h123, 12'h456);
    chk("normal", {30'h0, pwr}, {30'h0, DAR_PWR_NORMAL});
    pop(32'h0, 1'b0);
    $display("test power states done");
    for (i = 0; i < 16; i++) frame(6'h10, {i[3:0], 8'h5a}, {8'ha5, i[3:0]});
    @(negedge i_clk);
    start = 1'b1;
    repeat (600) @(negedge i_clk);
    chk("refused", {31'h0, busy}, 32'h0);
    start = 1'b0;
    for (i = 0; i < 16; i++) pop({w({i[3:0], 8'h5a}), w({8'ha5, i[3:0]})}, 1'b1);
    chk("empty", {31'h0, vld}, 32'h0);
    $display("test buffer fill done");
    tally_and_finish();
  end
endmodule
